// file: bench/dcs_partner.sv
// Arbiter and memory model on the far side of the channel's bus.
`timescale 1ns/10ps
module dcs_partner (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire dcs_pkg::dcs_bus_req_t bus_req,
    output dcs_pkg::dcs_bus_rsp_t      bus_rsp,
    input  wire logic                  ask,
    output logic                       bus_grant
);
    import dcs_pkg::*;
    // Grant trails the ask by a cycle and reads answer a cycle late.
    // Idle read data churns, so a stale word can never pass for data.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rsp   <= '0;
            bus_grant <= 1'b0;
        end else begin
            bus_grant     <= ask;
            bus_rsp.ready <= bus_req.req && !bus_rsp.ready;
            // Any access with the top address bit set answers an error.
            bus_rsp.err   <= bus_req.req && !bus_rsp.ready &&
                             bus_req.addr[31];
            bus_rsp.rdata <= ~bus_rsp.rdata;
            if (bus_req.req && !bus_rsp.ready) begin
                bus_rsp.rdata <= bus_req.addr ^ 32'h5A5A0000;
            end
        end
    end
endmodule // dcs_partner

// file: bench/tb.sv
// Self-checking bench for the DMA channel.
`timescale 1ns/10ps
module tb;
    import dcs_pkg::*;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata, rd, v;
    logic         pready, pslverr, se, coh, pln, grant, irq, ack, stb;
    logic         pin = 1'b0, yld = 1'b0, mon_on = 1'b0, coh_d1 = 1'b0;
    dcs_bus_req_t bus_req;
    dcs_bus_rsp_t bus_rsp;
    int           checks = 0, n_mismatch = 0, seed = 31493, n;
    int           wait_n = 0, ack_n = 0, stb_n = 0, pln_n = 0, rise_n = 0;
    logic [7:0]   offs [5] = '{OFF_STAT, OFF_SRC, OFF_DST, OFF_CNT,
                               OFF_HOLD};
    logic [31:0]  exps [5] = '{32'h00800000, 32'h108, 32'h208, 32'h0,
                               32'h104 ^ 32'h5A5A0000};

    // The yield input and the request pin are driven by the scenarios.
    dcs_channel i_dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .bus_req, .bus_rsp,
        .coherent_bus_request(coh), .plain_bus_request(pln),
        .bus_grant(grant), .yield_request(yld), .transfer_req_in(pin),
        .transfer_ack_out(ack), .cycle_start_strobe(stb), .irq);
    dcs_partner i_mem (.clk, .rst_n, .bus_req, .bus_rsp,
        .ask(coh | pln), .bus_grant(grant));

    // Clock of 40 ns period.
    always #20 clk = ~clk;

    // Counters for coherent-ask rises and for plain-ask, strobe and acknowledge cycles.
    always @(posedge clk) begin
        coh_d1 <= coh;
        if (coh && !coh_d1) begin
            rise_n <= rise_n + 1;
        end
        if (pln) begin
            pln_n <= pln_n + 1;
        end
        if (mon_on) begin
            // Cycles with the bus granted before the first strobe.
            if (grant && !bus_req.req && !stb && stb_n == 0) begin
                wait_n <= wait_n + 1;
            end
            if (stb) begin
                stb_n <= stb_n + 1;
            end
            if (ack) begin
                ack_n <= ack_n + 1;
            end
        end
    end

    // Compare and count; a mismatch prints both values.
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic wrap_up();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer. Ready is sampled at each rising edge of the
    // access phase; data are taken and the request released there.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 9);
        if (pready !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Bounded wait for the interrupt; running out counts a mismatch.
    task automatic wait_irq();
        for (n = 0; n < 300 && irq !== 1'b1; n++) begin
            @(posedge clk);
        end
        if (n == 300) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    // Reset, register checks, one transfer, a refused restart, a chained port transfer and a fault.
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, se}, 32'h1);
        repeat (4) begin
            v = $random(seed) & 32'h7EFFFFFF;
            apb(1'b1, OFF_CTRL, v);
            apb(1'b0, OFF_CTRL, 32'h0);
            chk(rd, v & CTRL_WMASK);
            apb(1'b1, OFF_STAT, v);
            apb(1'b0, OFF_STAT, 32'h0);
            chk(rd, v & 32'h7);
        end
        $display("test registers done");
        apb(1'b1, OFF_STAT, 32'h0);
        apb(1'b1, OFF_SRC, 32'h100);
        apb(1'b1, OFF_DST, 32'h200);
        apb(1'b1, OFF_CNT, 32'h8);
        // Yield asked and enabled: the bus is handed back between units.
        yld <= 1'b1;
        apb(1'b1, OFF_CTRL, 32'h80820C00);
        wait_irq();
        chk({31'h0, irq}, 32'h1);
        chk(rise_n, 32'h2);
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0);
            chk(rd, exps[i]);
        end
        $display("test transfer done");
        apb(1'b1, OFF_CTRL, 32'h80820800);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd, 32'h00C40000);
        apb(1'b1, OFF_STAT, 32'h0);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test refusal done");
        // Port to memory, single address, rising-edge request, chained.
        apb(1'b1, OFF_STAT, 32'h2);
        apb(1'b1, OFF_SRC, 32'h300);
        apb(1'b1, OFF_DST, 32'h400);
        apb(1'b1, OFF_CNT, 32'h4);
        apb(1'b1, OFF_NXT, 32'h4);
        apb(1'b1, OFF_CTRL, 32'h8023EB00);
        mon_on <= 1'b1;
        pin    <= 1'b1;
        wait_irq();
        pin    <= 1'b0;
        // Two wait clocks plus the grant and issue cycles.
        chk(wait_n, 32'h4);
        chk(stb_n, 32'h1);
        // Acknowledge stands from issue until the answer a cycle later.
        chk(ack_n, 32'h2);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd, 32'h80200002);
        apb(1'b0, OFF_SRC, 32'h0);
        chk(rd, 32'h300);
        apb(1'b0, OFF_DST, 32'h0);
        chk(rd, 32'h300);
        apb(1'b0, OFF_CNT, 32'h0);
        chk(rd, 32'h4);
        apb(1'b1, OFF_CTRL, 32'h0123EB00);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd, 32'h00200002);
        apb(1'b1, OFF_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        chk(pln_n, 32'h0);
        $display("test port chain done");
        // A source read that the far side answers with a bus error.
        apb(1'b1, OFF_SRC, 32'h80000000);
        apb(1'b1, OFF_CTRL, 32'h80420800);
        wait_irq();
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd, 32'h00500000);
        apb(1'b1, OFF_STAT, 32'h0);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test fault done");
        wrap_up();
    end
endmodule // tb

// file: hw/dcs_channel.sv
// One DMA channel: APB registers, request handling and transfer engine.
`timescale 1ns/10ps

module dcs_channel #(
    parameter int CNT_W = dcs_pkg::CNT_W
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [dcs_pkg::ADDR_W-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    output dcs_pkg::dcs_bus_req_t           bus_req,
    input  wire dcs_pkg::dcs_bus_rsp_t      bus_rsp,
    output logic                            coherent_bus_request,
    output logic                            plain_bus_request,
    input  wire logic                       bus_grant,
    input  wire logic                       yield_request,
    input  wire logic                       transfer_req_in,
    output logic                            transfer_ack_out,
    output logic                            cycle_start_strobe,
    output logic                            irq
);
    import dcs_pkg::*;

    // The counter width cannot exceed the documented register field.
    if (CNT_W < 4 || CNT_W > dcs_pkg::CNT_W) begin : g_bad_width
        $error("CNT_W must lie between 4 and 24.");
    end

    typedef struct packed {
        dcs_state_t       st;
        logic [31:0]      ctrl;
        logic             ok;
        logic             fail;
        logic             chain;
        logic             sfault;
        logic             dfault;
        logic             cfault;
        logic [BSW_W-1:0] start_strobe_wait;
        logic [BSW_W-1:0] bsw_cnt;
        logic [31:0]      src;
        logic [31:0]      dst;
        logic [31:0]      hold;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] nxt;
        logic             edge_pend;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        dcs_bus_req_t     bus;
        logic             coh;
        logic             plain;
        logic             ack_lvl;
        logic             ack_out;
        logic             strobe;
        logic             irq;
    } dcs_regs_t;

    dcs_regs_t        s_q;
    dcs_regs_t        s_d;
    logic [31:0]      rdat;
    logic             mapped;
    logic [31:0]      src_nx;
    logic [31:0]      dst_nx;
    logic             req_level;
    logic             req_edge;
    logic [2:0]       unit;
    logic [2:0]       port;
    logic             wr_acc;

    // Per-request size and port width decode.
    assign unit   = dcs_width_bytes(s_q.ctrl[UNIT_LSB +: 2]);
    assign port   = dcs_width_bytes(s_q.ctrl[PORT_LSB +: 2]);
    assign wr_acc = psel && penable && pwrite && s_q.pready && !s_q.pslverr;

    // Addresses step per their code by the port width at the end of every completed unit.
    dcs_step u_src_step (
        .addr  (s_q.src),
        .step  (s_q.ctrl[SSTEP_LSB +: 2]),
        .width (port),
        .next  (src_nx)
    );
    dcs_step u_dst_step (
        .addr  (s_q.dst),
        .step  (s_q.ctrl[DSTEP_LSB +: 2]),
        .width (port),
        .next  (dst_nx)
    );

    // The request pin comes from outside and is synchronised first.
    dcs_reqdet u_reqdet (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin       (transfer_req_in),
        .pol_high  (s_q.ctrl[B_POL]),
        .req_level (req_level),
        .req_edge  (req_edge)
    );

    // Read data mux; start and stop bits are never stored so read zero.
    always_comb begin
        rdat   = '0;
        mapped = 1'b1;
        unique case (paddr)
            OFF_CTRL: rdat = s_q.ctrl;
            OFF_STAT: begin
                rdat[S_ACT]    = (s_q.st == ST_WAIT);
                rdat[S_OK]     = s_q.ok;
                rdat[S_FAIL]   = s_q.fail;
                rdat[S_CHAIN]  = s_q.chain;
                rdat[S_SFAULT] = s_q.sfault;
                rdat[S_DFAULT] = s_q.dfault;
                rdat[S_CFAULT] = s_q.cfault;
                rdat[BSW_LSB +: BSW_W] = s_q.start_strobe_wait;
            end
            OFF_SRC:  rdat = s_q.src;
            OFF_DST:  rdat = s_q.dst;
            OFF_CNT:  rdat[CNT_W-1:0] = s_q.cnt;
            OFF_NXT:  rdat[CNT_W-1:0] = s_q.nxt;
            OFF_HOLD: rdat = s_q.hold;
            default:  mapped = 1'b0;
        endcase
    end

    // Next state: bus writes first, engine events after so a set wins.
    always_comb begin
        logic ext;
        logic single;
        logic pending;
        logic fin;
        logic [CNT_W-1:0] left;
        ext     = s_q.ctrl[B_EXT];
        single  = s_q.ctrl[B_ONE];
        pending = 1'b0;
        fin     = 1'b0;
        left    = '0;
        s_d        = s_q;
        s_d.strobe = 1'b0;
        // Zero-wait APB slave: ready is raised for the access phase.
        s_d.pready = psel && !penable;
        if (psel && !penable) begin
            s_d.prdata  = rdat;
            s_d.pslverr = !mapped;
        end
        if (wr_acc) begin
            unique case (paddr)
                OFF_CTRL: begin
                    // Stores byte order, chaining and all mode fields.
                    s_d.ctrl = pwdata & CTRL_WMASK;
                    if (pwdata[B_START]) begin
                        if (s_q.ok || s_q.fail) begin
                            s_d.fail   = 1'b1;
                            s_d.cfault = 1'b1;
                        end else if ((pwdata[B_SIO] && pwdata[B_DIO]) ||
                                     s_q.cnt == '0) begin
                            s_d.fail   = 1'b1;
                            s_d.cfault = 1'b1;
                        end else if (s_q.st == ST_HALT) begin
                            s_d.st        = ST_WAIT;
                            s_d.edge_pend = 1'b0;
                        end
                    end else if (pwdata[B_STOP] && s_q.st == ST_WAIT) begin
                        s_d.st = ST_HALT;
                    end
                end
                OFF_STAT: begin
                    if (!pwdata[S_OK]) begin
                        s_d.ok = 1'b0;
                    end
                    if (!pwdata[S_FAIL]) begin
                        s_d.fail   = 1'b0;
                        s_d.sfault = 1'b0;
                        s_d.dfault = 1'b0;
                        s_d.cfault = 1'b0;
                    end
                    if (!pwdata[S_CHAIN]) begin
                        s_d.chain = 1'b0;
                    end
                    s_d.start_strobe_wait = pwdata[BSW_LSB +: BSW_W];
                end
                OFF_SRC: s_d.src = pwdata;
                OFF_DST: s_d.dst = pwdata;
                OFF_CNT: s_d.cnt = pwdata[CNT_W-1:0];
                OFF_NXT: s_d.nxt = pwdata[CNT_W-1:0];
                default: s_d.ctrl = s_q.ctrl;
            endcase
        end
        // Edge mode keeps at most one pending request; further active edges merge into it.
        if (req_edge) begin
            s_d.edge_pend = 1'b1;
        end
        pending = !ext || (s_q.ctrl[B_LEV] ? req_level : s_q.edge_pend);
        unique case (s_q.st)
            ST_HALT: s_d.st = s_d.st;
            ST_WAIT: begin
                if (pending && s_d.st == ST_WAIT) begin
                    s_d.st        = ST_ARB;
                    s_d.edge_pend = req_edge;
                    s_d.coh       = s_q.ctrl[B_COH];
                    s_d.plain     = !s_q.ctrl[B_COH];
                end
            end
            ST_ARB: begin
                if (bus_grant) begin
                    s_d.st      = ST_XFER_A;
                    // Strobe wait only for port-to-memory single moves.
                    s_d.bsw_cnt = (single && s_q.ctrl[B_SIO]) ?
                                  s_q.start_strobe_wait : '0;
                end
            end
            ST_XFER_A: begin
                if (!s_q.bus.req) begin
                    if (s_q.bsw_cnt != '0) begin
                        s_d.bsw_cnt = s_q.bsw_cnt - 1'b1;
                    end else begin
                        s_d.bus.req   = 1'b1;
                        s_d.strobe    = 1'b1;
                        s_d.bus.bytes = unit;
                        // Single mode: one cycle, memory side addressed.
                        s_d.bus.we    = single && s_q.ctrl[B_SIO];
                        s_d.bus.addr  = (single && s_q.ctrl[B_SIO]) ?
                                        s_q.dst : s_q.src;
                        s_d.ack_lvl   = single || s_q.ctrl[B_SIO];
                    end
                end else if (bus_rsp.ready) begin
                    s_d.bus.req = 1'b0;
                    s_d.ack_lvl = 1'b0;
                    if (bus_rsp.err) begin
                        s_d.fail   = 1'b1;
                        s_d.sfault = 1'b1;
                        s_d.st     = ST_HALT;
                        s_d.coh    = 1'b0;
                        s_d.plain  = 1'b0;
                    end else if (single) begin
                        fin = 1'b1;
                    end else begin
                        s_d.hold = bus_rsp.rdata;
                        s_d.st   = ST_XFER_B;
                    end
                end
            end
            ST_XFER_B: begin
                if (!s_q.bus.req) begin
                    s_d.bus.req   = 1'b1;
                    s_d.strobe    = 1'b1;
                    s_d.bus.we    = 1'b1;
                    s_d.bus.bytes = unit;
                    s_d.bus.addr  = s_q.dst;
                    s_d.bus.wdata = s_q.hold;
                    s_d.ack_lvl   = s_q.ctrl[B_DIO];
                end else if (bus_rsp.ready) begin
                    s_d.bus.req = 1'b0;
                    s_d.ack_lvl = 1'b0;
                    if (bus_rsp.err) begin
                        s_d.fail   = 1'b1;
                        s_d.dfault = 1'b1;
                        s_d.st     = ST_HALT;
                        s_d.coh    = 1'b0;
                        s_d.plain  = 1'b0;
                    end else begin
                        fin = 1'b1;
                    end
                end
            end
        endcase
        // End of one unit: step pointers, count down, decide what next.
        if (fin) begin
            s_d.src = src_nx;
            s_d.dst = dst_nx;
            left    = (s_q.cnt > CNT_W'(unit)) ?
                      s_q.cnt - CNT_W'(unit) : '0;
            s_d.cnt = left;
            if (left == '0) begin
                s_d.coh   = 1'b0;
                s_d.plain = 1'b0;
                if (s_q.ctrl[B_CONT] && single) begin
                    // Port side holds the next memory start address.
                    s_d.chain = 1'b1;
                    s_d.cnt   = s_q.nxt;
                    if (s_q.ctrl[B_SIO]) begin
                        s_d.dst = s_q.src;
                    end else begin
                        s_d.src = s_q.dst;
                    end
                    s_d.st = ST_WAIT;
                end else begin
                    s_d.ok = 1'b1;
                    s_d.st = ST_HALT;
                end
            end else if (!ext && !(yield_request && s_q.ctrl[B_YLD])) begin
                s_d.st = ST_XFER_A;
            end else begin
                // Yielding or external: give the bus back at the break.
                s_d.st    = ST_WAIT;
                s_d.coh   = 1'b0;
                s_d.plain = 1'b0;
            end
        end
        // Acknowledge polarity only matters in external mode.
        s_d.ack_out = (ext && !s_q.ctrl[B_POL]) ?
                      !s_d.ack_lvl : s_d.ack_lvl;
        s_d.irq = (s_d.ok    && s_d.ctrl[B_OK_IE])   ||
                  (s_d.fail  && s_d.ctrl[B_FAIL_IE]) ||
                  (s_d.chain && s_d.ctrl[B_CHAIN_IE]);
    end

    // All channel state but the request pin synchroniser in u_reqdet lives in one register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q      <= '0;
            s_q.ctrl <= CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Every output is a field of the state register.
    assign prdata               = s_q.prdata;
    assign pready               = s_q.pready;
    assign pslverr              = s_q.pslverr;
    assign bus_req              = s_q.bus;
    assign coherent_bus_request = s_q.coh;
    assign plain_bus_request    = s_q.plain;
    assign transfer_ack_out     = s_q.ack_out;
    assign cycle_start_strobe   = s_q.strobe;
    assign irq                  = s_q.irq;

    // Checks on the channel's own behaviour.
    property p_act_read;
        @(posedge clk) disable iff (!rst_n)
        (psel && !penable && paddr == OFF_STAT) |=>
            (prdata[S_ACT] == ($past(s_q.st) == ST_WAIT));
    endproperty
    a_act_read: assert property (p_act_read)
        else $error("Active bit does not match the waiting state.");

    property p_ok_clear;
        @(posedge clk) disable iff (!rst_n)
        (wr_acc && paddr == OFF_STAT && !pwdata[S_OK] &&
         s_q.st == ST_HALT) |=> !s_q.ok ##1 !(irq && !s_q.fail && !s_q.chain);
    endproperty
    a_ok_clear: assert property (p_ok_clear)
        else $error("Normal flag or its interrupt survived a clear.");

    property p_fail_clear;
        @(posedge clk) disable iff (!rst_n)
        (wr_acc && paddr == OFF_STAT && !pwdata[S_FAIL] &&
         s_q.st == ST_HALT) |=>
            !s_q.fail && !s_q.sfault && !s_q.dfault && !s_q.cfault;
    endproperty
    a_fail_clear: assert property (p_fail_clear)
        else $error("Abnormal clear left a fault flag set.");

    property p_start_err;
        @(posedge clk) disable iff (!rst_n)
        (wr_acc && paddr == OFF_CTRL && pwdata[B_START] &&
         s_q.st == ST_HALT && (s_q.ok || s_q.fail)) |=>
            s_q.st == ST_HALT && s_q.fail && s_q.cfault;
    endproperty
    a_start_err: assert property (p_start_err)
        else $error("Start with a done flag set did not fail.");

    property p_irq_on;
        @(posedge clk) disable iff (!rst_n)
        (s_q.ok && s_q.ctrl[B_OK_IE]) [*2] |-> irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("Enabled normal flag raised no interrupt.");

    property p_ack_low;
        @(posedge clk) disable iff (!rst_n)
        (s_q.ctrl[B_EXT] && !s_q.ctrl[B_POL] && !s_q.ack_lvl) [*2]
            |-> transfer_ack_out;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("Low-active acknowledge not idle high.");

    property p_coh;
        @(posedge clk) disable iff (!rst_n)
        $rose(coherent_bus_request) |->
            $past(s_q.ctrl[B_COH]) && !plain_bus_request;
    endproperty
    a_coh: assert property (p_coh)
        else $error("Coherent request raised with the plain mode.");

    property p_cnt;
        @(posedge clk) disable iff (!rst_n)
        (s_q.st == ST_XFER_B && s_q.bus.req && bus_rsp.ready &&
         !bus_rsp.err && s_q.cnt > CNT_W'(unit) && !wr_acc) |=>
            (s_q.cnt + CNT_W'($past(unit)) == $past(s_q.cnt));
    endproperty
    a_cnt: assert property (p_cnt)
        else $error("Counter did not drop by the transfer unit.");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        (s_q.st == ST_XFER_A && !s_q.ctrl[B_ONE] && s_q.bus.req &&
         bus_rsp.ready && !bus_rsp.err) |=>
            s_q.hold == $past(bus_rsp.rdata) && s_q.st == ST_XFER_B;
    endproperty
    a_hold: assert property (p_hold)
        else $error("Holding register missed the source word.");

    c_ok: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(s_q.ok));
    c_chain: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(s_q.chain));
    c_fault: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(s_q.sfault || s_q.dfault));
endmodule // dcs_channel

// file: hw/dcs_reqdet.sv
// Synchroniser and level or edge detector for the request pin.
`timescale 1ns/10ps
module dcs_reqdet (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    input  wire logic pol_high,
    output logic      req_level,
    output logic      req_edge
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } dcs_det_t;

    dcs_det_t s_q;
    dcs_det_t s_d;

    // Only the second stage looks at the first one.
    always_comb begin
        s_d      = s_q;
        s_d.s1   = pin;
        s_d.s2   = s_q.s1;
        s_d.prev = s_q.s2;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Active level and the transition into it follow the polarity.
    assign req_level = pol_high ? s_q.s2 : !s_q.s2;
    assign req_edge  = pol_high ? (s_q.s2 && !s_q.prev)
                                : (!s_q.s2 && s_q.prev);
endmodule // dcs_reqdet

// file: hw/dcs_step.sv
// Address stepper applying the fix, decrement or increment code.
`timescale 1ns/10ps
module dcs_step (
    input  wire logic [31:0] addr,
    input  wire logic [1:0]  step,
    input  wire logic [2:0]  width,
    output logic      [31:0] next
);
    // Code 1x holds, 01 steps down, 00 steps up by the port width.
    always_comb begin
        if (step[1]) begin
            next = addr;
        end else if (step[0]) begin
            next = addr - {29'h0000000, width};
        end else begin
            next = addr + {29'h0000000, width};
        end
    end
endmodule // dcs_step

// file: shared/dcs_pkg.sv
// Shared constants, types and helpers of the DMA channel block.
package dcs_pkg;

    // Register byte offsets on the APB side.
    localparam int          ADDR_W   = 8;
    localparam logic [7:0]  OFF_CTRL = 8'h00;
    localparam logic [7:0]  OFF_STAT = 8'h04;
    localparam logic [7:0]  OFF_SRC  = 8'h08;
    localparam logic [7:0]  OFF_DST  = 8'h0C;
    localparam logic [7:0]  OFF_CNT  = 8'h10;
    localparam logic [7:0]  OFF_NXT  = 8'h14;
    localparam logic [7:0]  OFF_HOLD = 8'h8C;

    // Channel control bit positions.
    localparam int B_START    = 31;
    localparam int B_STOP     = 24;
    localparam int B_OK_IE    = 23;
    localparam int B_FAIL_IE  = 22;
    localparam int B_CHAIN_IE = 21;
    localparam int B_BIG      = 17;
    localparam int B_CONT     = 16;
    localparam int B_ONE      = 15;
    localparam int B_EXT      = 14;
    localparam int B_POL      = 13;
    localparam int B_LEV      = 12;
    localparam int B_COH      = 11;
    localparam int B_YLD      = 10;
    localparam int B_SIO      = 9;
    localparam int SSTEP_LSB  = 7;
    localparam int B_DIO      = 6;
    localparam int DSTEP_LSB  = 4;
    localparam int UNIT_LSB   = 2;
    localparam int PORT_LSB   = 0;
    localparam logic [31:0] CTRL_RESET = 32'h00E20000;
    localparam logic [31:0] CTRL_WMASK = 32'h00EFFFFF;

    // Channel status bit positions.
    localparam int S_ACT    = 31;
    localparam int S_OK     = 23;
    localparam int S_FAIL   = 22;
    localparam int S_CHAIN  = 21;
    localparam int S_SFAULT = 20;
    localparam int S_DFAULT = 19;
    localparam int S_CFAULT = 18;
    localparam int BSW_LSB  = 0;
    localparam int BSW_W    = 3;

    // Documented width of the byte counters.
    localparam int CNT_W = 24;

    // One memory-side access and its answer.
    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [2:0]  bytes;
    } dcs_bus_req_t;

    typedef struct packed {
        logic        ready;
        logic        err;
        logic [31:0] rdata;
    } dcs_bus_rsp_t;

    typedef enum logic [2:0] {
        ST_HALT, ST_WAIT, ST_ARB, ST_XFER_A, ST_XFER_B
    } dcs_state_t;

    // Byte count of a size code: 11 one byte, 10 two bytes, 0x four.
    function automatic logic [2:0] dcs_width_bytes(input logic [1:0] code);
        if (code == 2'h3) begin
            return 3'h1;
        end
        return code[1] ? 3'h2 : 3'h4;
    endfunction

endpackage
